// File: rtl/bscc_consts.vh
// Constants for the boost switching clock control block.
`ifndef BSCC_CONSTS_VH
`define BSCC_CONSTS_VH
`define BSCC_CLK_HZ 50000000
`define BSCC_SS_DELAY_US 256
`define BSCC_SS_DELAY_CYC ((`BSCC_SS_DELAY_US * (`BSCC_CLK_HZ / 1000000)))
`define BSCC_ILIM_HOLD_MS 1500
`define BSCC_ILIM_HOLD_CYC (`BSCC_ILIM_HOLD_MS * (`BSCC_CLK_HZ / 1000))
`define BSCC_WIN_US 10
`define BSCC_WIN_CYC (`BSCC_WIN_US * (`BSCC_CLK_HZ / 1000000))
`define BSCC_SYNC_MIN_KHZ 300
`define BSCC_SYNC_MAX_KHZ 2200
`define BSCC_RANGE1_KHZ 480
`define BSCC_RANGE2_KHZ 1150
`define BSCC_RANGE3_KHZ 1650
`define BSCC_SS_DEV_PCT 3
`define BSCC_SS_MOD_HZ 1000
`define BSCC_SS_TRI_STEPS 64
`define BSCC_SS_STEP_CYC (`BSCC_CLK_HZ / (`BSCC_SS_MOD_HZ * 2 * (`BSCC_SS_TRI_STEPS - 1)))
`define BSCC_RESET_PERIOD 16'h00A6
`endif

// File: rtl/bscc_sync2.v
// Two-flop synchroniser for one asynchronous level.
`timescale 1ns/1ns
module bscc_sync2 (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_sys_rst,
  // Asynchronous level in, synchronised level out
  input wire i_async,
  output reg o_sync
);
  reg meta_r;
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      meta_r <= 1'b0;
      o_sync <= 1'b0;
    end
    else
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule // bscc_sync2

// File: rtl/bscc_top.v
// Switching clock source selection, spread spectrum, range, current limit and sink detection.
`timescale 1ns/1ns
`include "bscc_consts.vh"
// Summary of operation
// - Lock the switching clock to a 300 kHz to 2.2 MHz sync clock.
// - When sync clock stops, keep switching at the resistor-set frequency.
// - Clock stops with sync low: continue at once without spread spectrum.
// - Clock stops with sync high: enable spread spectrum after 256 us.
// - Spread spectrum modulates plus or minus three percent at 1 kHz.
// - Never modulate while locked to the external clock.
// - Static low disables, static high enables, toggling selects external sync.
// - Pick loop parameter range from boundaries at 480, 1150, 1650 kHz.
// - Limit is 2 A; on reaching it raise to 2.5 A for 1.5 s.
// - Under sustained overload alternate 2 A and 2.5 A every 1.5 s.
// - A 48 V comparator stops switching regardless of the feedback loop.
// - At start-up disable and exclude each grounded LED sink output.
module bscc_top #(
  parameter NUM_SINKS = 4,
  parameter PERIOD_W = 16,
  parameter ILIM_HOLD_CYC = `BSCC_ILIM_HOLD_CYC,
  parameter SS_DELAY_CYC = `BSCC_SS_DELAY_CYC,
  parameter WIN_CYC = `BSCC_WIN_CYC
) (
  // Clock and reset (reset is the device enable)
  input wire i_clk_sys,
  input wire i_sys_rst,
  // Sync pin and resistor-set period (system cycles per switching period)
  input wire i_sync,
  input wire [PERIOD_W-1:0] i_frequency_set_resistor_pin_period,
  // Analog comparator flags
  input wire i_ilim_hit,
  input wire i_switch_node_ovp,
  input wire [NUM_SINKS-1:0] i_led_sink_output_grounded,
  input wire i_startup_done,
  // Switching clock and mode
  output reg o_sw_clk,
  output reg o_ext_sync_mode,
  output reg o_ss_active,
  output reg [1:0] o_freq_range,
  output reg o_ilim_high,
  output reg o_switch_enable,
  output reg [NUM_SINKS-1:0] o_sink_enable
);
  localparam CW = 28;
  localparam ST_FREE = 3'b001;
  localparam ST_EXT = 3'b010;
  localparam ST_WAIT = 3'b100;
  wire sync_s;
  reg sync_d_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [CW-1:0] win_cnt_r;
  reg [3:0] edge_cnt_r;
  reg toggling_r;
  reg [CW-1:0] ext_per_cnt_r;
  reg [PERIOD_W-1:0] ext_period_r;
  reg [CW-1:0] delay_cnt_r;
  reg [PERIOD_W-1:0] osc_cnt_r;
  reg [CW-1:0] ss_step_cnt_r;
  reg [5:0] ss_tri_r;
  reg ss_up_r;
  reg [CW-1:0] ilim_cnt_r;
  reg ilim_busy_r;
  reg sinks_latched_r;
  reg [2:0] settle_r;
  wire rise = sync_s & ~sync_d_r & settle_r[2];
  wire win_end = (win_cnt_r == WIN_CYC - 1);
  wire [PERIOD_W-1:0] ss_dev;
  wire [PERIOD_W-1:0] free_period;
  wire [PERIOD_W-1:0] act_period;
  bscc_sync2 u_sync (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_async(i_sync),
    .o_sync(sync_s)
  );
  // Edge counting separates a clock from a level; a pin resting high after reset is no edge.
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      sync_d_r <= 1'b0;
      settle_r <= 3'h0;
      win_cnt_r <= {CW{1'b0}};
      edge_cnt_r <= 4'h0;
      toggling_r <= 1'b0;
    end
    else
    begin
      sync_d_r <= sync_s;
      settle_r <= {settle_r[1:0], 1'b1};
      if (win_end)
      begin
        win_cnt_r <= {CW{1'b0}};
        toggling_r <= (edge_cnt_r != 4'h0) || rise;
        edge_cnt_r <= 4'h0;
      end
      else
      begin
        win_cnt_r <= win_cnt_r + 1'b1;
        if (rise && edge_cnt_r != 4'hF)
          edge_cnt_r <= edge_cnt_r + 1'b1;
      end
    end
  end
  // Measure the external period between rising edges.
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      ext_per_cnt_r <= {CW{1'b0}};
      ext_period_r <= `BSCC_RESET_PERIOD;
    end
    else if (rise)
    begin
      ext_per_cnt_r <= {CW{1'b0}};
      ext_period_r <= ext_per_cnt_r[PERIOD_W-1:0] + 1'b1;
    end
    else if (ext_per_cnt_r != {CW{1'b1}})
      ext_per_cnt_r <= ext_per_cnt_r + 1'b1;
  end
  // Mode selection by the sync pin.
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_FREE:
        if (toggling_r)
          state_nxt = ST_EXT;
      ST_EXT:
        if (!toggling_r)
          state_nxt = sync_s ? ST_WAIT : ST_FREE;
      ST_WAIT:
        if (toggling_r)
          state_nxt = ST_EXT;
        else if (!sync_s)
          state_nxt = ST_FREE;
      default:
        state_nxt = ST_FREE;
    endcase
  end
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      state_r <= ST_FREE;
      delay_cnt_r <= {CW{1'b0}};
      o_ext_sync_mode <= 1'b0;
      o_ss_active <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      o_ext_sync_mode <= (state_nxt == ST_EXT);
      if (state_nxt == ST_WAIT && state_r != ST_WAIT)
        delay_cnt_r <= {CW{1'b0}};
      else if (state_r == ST_WAIT && delay_cnt_r != SS_DELAY_CYC)
        delay_cnt_r <= delay_cnt_r + 1'b1;
      // Entering free-run from a static high right after reset is not delayed.
      if (state_nxt == ST_EXT)
        o_ss_active <= 1'b0;
      else if (state_nxt == ST_WAIT)
        o_ss_active <= (state_r == ST_WAIT) && (delay_cnt_r == SS_DELAY_CYC);
      else
        o_ss_active <= sync_s && !rise && (edge_cnt_r == 4'h0);
    end
  end
  // Triangle modulation of the period, deviation up to period * 3/100.
  wire [31:0] ss_span_w = i_frequency_set_resistor_pin_period * `BSCC_SS_DEV_PCT / 100;
  wire [31:0] ss_dev_w = ss_span_w * ss_tri_r / 63;
  wire [31:0] ss_period_w = i_frequency_set_resistor_pin_period - ss_span_w + {ss_dev, 1'b0};
  assign ss_dev = ss_dev_w[PERIOD_W-1:0];
  assign free_period = o_ss_active ? ss_period_w[PERIOD_W-1:0] : i_frequency_set_resistor_pin_period;
  assign act_period = (state_r == ST_EXT) ? ext_period_r : free_period;
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      ss_step_cnt_r <= {CW{1'b0}};
      ss_tri_r <= 6'h00;
      ss_up_r <= 1'b1;
    end
    else if (ss_step_cnt_r == `BSCC_SS_STEP_CYC - 1)
    begin
      ss_step_cnt_r <= {CW{1'b0}};
      if (ss_up_r)
      begin
        ss_tri_r <= ss_tri_r + 1'b1;
        ss_up_r <= (ss_tri_r != 6'h3E);
      end
      else
      begin
        ss_tri_r <= ss_tri_r - 1'b1;
        ss_up_r <= (ss_tri_r == 6'h01);
      end
    end
    else
      ss_step_cnt_r <= ss_step_cnt_r + 1'b1;
  end
  // Switching clock generator; in external mode it realigns to each rising sync edge.
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      osc_cnt_r <= {PERIOD_W{1'b0}};
      o_sw_clk <= 1'b0;
    end
    else if ((state_r == ST_EXT && rise) || osc_cnt_r >= act_period - 1'b1)
    begin
      osc_cnt_r <= {PERIOD_W{1'b0}};
      o_sw_clk <= 1'b1;
    end
    else
    begin
      osc_cnt_r <= osc_cnt_r + 1'b1;
      if (osc_cnt_r == (act_period >> 1))
        o_sw_clk <= 1'b0;
    end
  end
  // Range from the active period: f_khz = CLK_HZ / (1000 * period).
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      o_freq_range <= 2'd0;
    else if (act_period > `BSCC_CLK_HZ / (1000 * `BSCC_RANGE1_KHZ))
      o_freq_range <= 2'd0;
    else if (act_period > `BSCC_CLK_HZ / (1000 * `BSCC_RANGE2_KHZ))
      o_freq_range <= 2'd1;
    else if (act_period > `BSCC_CLK_HZ / (1000 * `BSCC_RANGE3_KHZ))
      o_freq_range <= 2'd2;
    else
      o_freq_range <= 2'd3;
  end
  // Two-level current limit; a sustained hit alternates the phases.
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      ilim_cnt_r <= {CW{1'b0}};
      ilim_busy_r <= 1'b0;
      o_ilim_high <= 1'b0;
    end
    else if (!ilim_busy_r)
    begin
      if (i_ilim_hit)
      begin
        ilim_busy_r <= 1'b1;
        o_ilim_high <= 1'b1;
        ilim_cnt_r <= {CW{1'b0}};
      end
    end
    else if (ilim_cnt_r == ILIM_HOLD_CYC - 1)
    begin
      ilim_cnt_r <= {CW{1'b0}};
      if (o_ilim_high)
        o_ilim_high <= 1'b0;
      else if (i_ilim_hit)
        o_ilim_high <= 1'b1;
      else
        ilim_busy_r <= 1'b0;
    end
    else
      ilim_cnt_r <= ilim_cnt_r + 1'b1;
  end

  // The overvoltage cut acts independently of the loop.
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      o_switch_enable <= 1'b0;
    else
      o_switch_enable <= ~i_switch_node_ovp;
  end

  // Grounded sinks are caught once, at the end of start-up.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SINKS; gi = gi + 1)
    begin : g_sink
      always @(posedge i_clk_sys)
      begin
        if (i_sys_rst)
          o_sink_enable[gi] <= 1'b0;
        else if (i_startup_done && !sinks_latched_r)
          o_sink_enable[gi] <= ~i_led_sink_output_grounded[gi];
      end
    end
  endgenerate

  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      sinks_latched_r <= 1'b0;
    else if (i_startup_done)
      sinks_latched_r <= 1'b1;
  end
endmodule // bscc_top

// File: verification/bscc_top_asserts.sv
// Assertion checker for the boost switching clock control block.
`timescale 1ns/1ns
module bscc_top_asserts #(
  parameter int NUM_SINKS = 4,
  parameter int PERIOD_W = 16,
  parameter int ILIM_HOLD_CYC = 100,
  parameter int SS_DELAY_CYC = 20,
  parameter int WIN_CYC = 50
) (
  // Clock and reset
  input logic i_clk_sys,
  input logic i_sys_rst,
  // Inputs
  input logic i_sync,
  input logic [PERIOD_W-1:0] i_frequency_set_resistor_pin_period,
  input logic i_ilim_hit,
  input logic i_switch_node_ovp,
  input logic [NUM_SINKS-1:0] i_led_sink_output_grounded,
  input logic i_startup_done,
  // Outputs
  input logic o_sw_clk,
  input logic o_ext_sync_mode,
  input logic o_ss_active,
  input logic [1:0] o_freq_range,
  input logic o_ilim_high,
  input logic o_switch_enable,
  input logic [NUM_SINKS-1:0] o_sink_enable
);
  localparam int SS_LO = SS_DELAY_CYC - 2;
  localparam int SS_HI = SS_DELAY_CYC + 6;
  logic [31:0] hi_cnt_r;
  logic [31:0] still_cnt_r;
  logic seen_r;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst || !o_switch_enable)
    begin
      still_cnt_r <= 0;
    end
    else
    begin
      still_cnt_r <= $stable(o_sw_clk) ? still_cnt_r + 1 : 0;
    end
    hi_cnt_r <= (o_ilim_high && !i_sys_rst) ? hi_cnt_r + 1 : 0;
    seen_r <= !i_sys_rst && (seen_r || i_startup_done);
  end
  ss_ext_excl_a: assert property (!(o_ext_sync_mode && o_ss_active))
    else $error("spread spectrum while locked");
  ovp_stop_a: assert property (i_switch_node_ovp |=> !o_switch_enable)
    else $error("switching not stopped on overvoltage");
  ilim_cause_a: assert property ($rose(o_ilim_high) |-> $past(i_ilim_hit))
    else $error("high limit without a limit hit");
  ilim_hold_a: assert property ($fell(o_ilim_high) |->
    (hi_cnt_r >= ILIM_HOLD_CYC - 1 && hi_cnt_r <= ILIM_HOLD_CYC + 1))
    else $error("high limit held for wrong time");
  sink_latch_a: assert property ($rose(i_startup_done) |->
    ##[1:2] o_sink_enable == ~i_led_sink_output_grounded)
    else $error("grounded sinks not disabled");
  sink_early_a: assert property (o_sink_enable != 0 |-> seen_r)
    else $error("sink enabled before start-up");
  ss_late_a: assert property ($fell(o_ext_sync_mode) && i_sync |->
    !o_ss_active ##[SS_LO:SS_HI] o_ss_active)
    else $error("spread spectrum delay wrong");
  ss_low_off_a: assert property ($fell(o_ext_sync_mode) && !i_sync |->
    !o_ss_active [*8])
    else $error("spread spectrum after low stop");
  clk_alive_a: assert property (still_cnt_r <= i_frequency_set_resistor_pin_period + 2 * WIN_CYC + 8)
    else $error("switching clock stalled");
endmodule // bscc_top_asserts
bind bscc_top bscc_top_asserts #(.NUM_SINKS(NUM_SINKS), .PERIOD_W(PERIOD_W),
  .ILIM_HOLD_CYC(ILIM_HOLD_CYC), .SS_DELAY_CYC(SS_DELAY_CYC), .WIN_CYC(WIN_CYC)) u_chk (.*);

// File: verification/bscc_sync_src.sv
// Model of the external clock source on the sync pin.
`timescale 1ns/1ns
module bscc_sync_src #(
  parameter HALF_NS = 80
) (
  // Control from the bench
  input wire i_run,
  input wire i_level,
  // Sync pin
  output reg o_sync
);
  // Odd start offset keeps the source edges away from the system clock edges.
  initial
  begin
    o_sync = 1'b0;
    #7;
    forever
    begin
      #(HALF_NS);
      if (i_run)
        o_sync = ~o_sync;
      else
        o_sync = i_level;
    end
  end
endmodule // bscc_sync_src

// File: verification/boost_switching_clock_control_tb.sv
// Self-checking testbench for the boost switching clock control block.
`timescale 1ns/1ns
module boost_switching_clock_control_tb;
  localparam ILIM = 100;
  localparam SSD = 20;
  localparam WIN = 50;
  reg clk = 0, rst = 1, run = 0, lvl = 0, hit = 0, ovp = 0, start = 0, p = 0;
  reg [15:0] per = 16'h0019;
  reg [3:0] gnd = 4'h5;
  wire sync, swc, ext, ss, ilh, swe;
  wire [1:0] rng;
  wire [3:0] sen;
  integer error_cnt = 0, n_checks = 0, cyc = 0, i, k;
  reg [15:0] pt [0:3];
  always #10 clk = ~clk;
  bscc_sync_src u_src (.i_run(run), .i_level(lvl), .o_sync(sync));
  bscc_top #(.ILIM_HOLD_CYC(ILIM), .SS_DELAY_CYC(SSD), .WIN_CYC(WIN)) dut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_sync(sync), .i_frequency_set_resistor_pin_period(per),
    .i_ilim_hit(hit), .i_switch_node_ovp(ovp), .i_led_sink_output_grounded(gnd),
    .i_startup_done(start), .o_sw_clk(swc), .o_ext_sync_mode(ext), .o_ss_active(ss),
    .o_freq_range(rng), .o_ilim_high(ilh), .o_switch_enable(swe), .o_sink_enable(sen));
  task end_sim;
    begin
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
      end
    end
  endtask
  task w(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  // Counts rising edges of the switching clock over 80 system cycles.
  task n_rise;
    begin
      k = 0;
      p = swc;
      for (i = 0; i < 80; i = i + 1)
      begin
        w(1);
        k = k + (swc && !p);
        p = swc;
      end
    end
  endtask
  task t_sink;
    begin
      w(3);
      chk(sen, 0);
      chk(swe, 1);
      @(posedge clk) start <= 1;
      w(4);
      chk(sen, 4'ha);
    end
  endtask
  task t_range;
    begin
      // Ascending periods so a half period never outlasts the new setting.
      for (i = 0; i < 4; i = i + 1)
      begin
        @(posedge clk) per <= pt[i];
        w(600);
        chk(rng, 3 - i);
        chk({ext, ss}, 0);
      end
    end
  endtask
  task t_ext(input stop_lvl);
    begin
      @(posedge clk) per <= 16'h000a;
      run <= 1;
      w(4 * WIN);
      chk({ext, ss}, 2'b10);
      n_rise;
      chk(k, 10);
      @(posedge clk) lvl <= stop_lvl;
      run <= 0;
      for (i = 0; i < 3 * WIN && ext; i = i + 1)
        w(1);
      chk({ext, ss}, 0);
      w(SSD + 8);
      chk(ss, stop_lvl);
      n_rise;
      chk(k, 8);
    end
  endtask
  task t_ilim;
    begin
      @(posedge clk) hit <= 1;
      w(1);
      chk(ilh, 1);
      w(ILIM - 5);
      chk(ilh, 1);
      w(10);
      chk(ilh, 0);
      w(ILIM - 10);
      chk(ilh, 0);
      w(10);
      chk(ilh, 1);
      @(posedge clk) hit <= 0;
      w(ILIM + 10);
      chk(ilh, 0);
    end
  endtask
  task t_ovp;
    begin
      @(posedge clk) ovp <= 1;
      w(3);
      chk(swe, 0);
      @(posedge clk) ovp <= 0;
      w(3);
      chk(swe, 1);
    end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 12000)
    begin
      error_cnt = error_cnt + 1;
      end_sim;
    end
  end
  initial
  begin
    pt[0] = 16'h0019;
    pt[1] = 16'h0028;
    pt[2] = 16'h0050;
    pt[3] = 16'h00c8;
    repeat (10) @(posedge clk);
    rst <= 0;
    t_sink;
    t_range;
    t_ext(0);
    t_ext(1);
    t_ilim;
    t_ovp;
    end_sim;
  end
endmodule // boost_switching_clock_control_tb
